// ### rtl/tpms_oneshot.sv
// Retriggerable one-shot with abort and optional inverted output
`timescale 1ns/1ps
module tpms_oneshot #(
    parameter int W = 16,
    parameter logic INV = 1'b0
) (
    input wire logic i_mclk,
    input wire logic i_reset_n,
    input wire logic i_start,
    input wire logic i_abort,
    input wire logic [W-1:0] i_len,
    output logic o_out
);
    typedef struct packed {
        logic [W-1:0] cnt;
        logic out;
    } tpms_shot_t;

    tpms_shot_t st_ff;
    tpms_shot_t nxt_st;

    if (W < 2) begin : g_chk
        $error("tpms_oneshot counter too narrow");
    end

    always_comb begin
        nxt_st = st_ff;
        if (i_abort) begin
            nxt_st.cnt = '0;
        end else if (i_start) begin
            nxt_st.cnt = i_len;
        end else if (st_ff.cnt != '0) begin
            nxt_st.cnt = st_ff.cnt - 1'b1;
        end
        nxt_st.out = (nxt_st.cnt != '0) ^ INV;
    end

    always_ff @(posedge i_mclk) begin
        if (!i_reset_n) begin
            st_ff <= '{cnt: '0, out: INV};
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign o_out = st_ff.out;
endmodule : tpms_oneshot

// ### rtl/tpms_pkg.sv
// Constants shared by the transmit pulse and motor supervisor
package tpms_pkg;
    localparam int CLK_MHZ = 125;
    // Coarse pulse widths, upper end of each range
    localparam int PW_SP_NS = 100;
    localparam int PW_MP_NS = 250;
    localparam int PW_LP_NS = 450;
    localparam int PW_VLP_NS = 1200;
    localparam int PW_SP_CYC = (PW_SP_NS * CLK_MHZ + 999) / 1000;
    localparam int PW_MP_CYC = (PW_MP_NS * CLK_MHZ + 999) / 1000;
    localparam int PW_LP_CYC = (PW_LP_NS * CLK_MHZ + 999) / 1000;
    localparam int PW_VLP_CYC = (PW_VLP_NS * CLK_MHZ + 999) / 1000;
    // Least spacing between pulses, just above the 3.0 kHz nominal top rate
    localparam int MIN_PRI_NS = 300_000;
    localparam int MIN_PRI_CYC = (MIN_PRI_NS * CLK_MHZ + 999) / 1000;
    localparam int HEAD_NS = 30_000;
    localparam int HEAD_CYC = (HEAD_NS * CLK_MHZ + 999) / 1000;
    localparam int PWM_PERIOD_NS = 40_000;
    localparam int PWM_CYC = PWM_PERIOD_NS * CLK_MHZ / 1000;
    localparam int FAULT_MS = 10_000;
    localparam int FAULT_CYC = FAULT_MS * CLK_MHZ * 1000;
    // Register map
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_STAT = 8'h04;
    localparam logic [7:0] REG_MASK = 8'h08;
    localparam logic [7:0] REG_STATE = 8'h0C;
    localparam logic [7:0] REG_DUTY = 8'h10;
    localparam int CTRL_RUN = 0;
    localparam int ST_FIRE = 0;
    localparam int ST_DROP = 1;
    localparam int ST_HEAD = 2;
    localparam int ST_LATCH = 3;
    localparam int ST_OCUT = 4;
    localparam int ST_W = 5;
    localparam logic CTRL_RUN_RST = 1'b0;
    localparam logic [ST_W-1:0] MASK_RST = 5'h00;
    localparam logic [15:0] DUTY_RST = 16'h09C4;
endpackage : tpms_pkg

// ### rtl/tpms_sync.sv
// Two-flop synchroniser for asynchronous inputs
`timescale 1ns/1ps
module tpms_sync #(
    parameter int W = 1
) (
    input wire logic i_mclk,
    input wire logic i_reset_n,
    input wire logic [W-1:0] i_async,
    output logic [W-1:0] o_sync
);
    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
    } tpms_sync_t;

    tpms_sync_t st_ff;
    tpms_sync_t nxt_st;

    if (W < 1) begin : g_chk
        $error("tpms_sync width must be at least one");
    end

    always_comb begin
        nxt_st.s1 = i_async;
        nxt_st.s2 = st_ff.s1;
    end

    always_ff @(posedge i_mclk) begin
        if (!i_reset_n) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    // Only the second stage is visible
    assign o_sync = st_ff.s2;
endmodule : tpms_sync

// ### rtl/tpms_top.sv
// Transmit pulse and antenna motor supervisor
`timescale 1ns/1ps
module tpms_top
    import tpms_pkg::*;
#(
    parameter int MIN_PRI_CYCLES = MIN_PRI_CYC,
    parameter int PWM_CYCLES = PWM_CYC,
    parameter int FAULT_CYCLES = FAULT_CYC
) (
    input wire logic i_mclk,
    input wire logic i_reset_n,
    input wire logic i_coarse_width_sel_lo,
    input wire logic i_coarse_width_sel_hi,
    input wire logic i_fire_trigger,
    input wire logic i_tx_enable,
    input wire logic i_over_temp,
    input wire logic i_heater_current_ok,
    input wire logic i_heading_sensor_n,
    input wire logic i_rotor_sensor_a,
    input wire logic i_rotor_sensor_b,
    input wire logic i_rotor_sensor_c,
    input wire logic i_over_speed,
    input wire logic i_over_current,
    input wire logic i_tx_reselect,
    input wire logic [7:0] i_addr,
    input wire logic [31:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [31:0] o_rdata,
    output logic o_tx_pulse,
    output logic o_heater_ok,
    output logic o_heading_pulse_n,
    output logic [2:0] o_phase_hi,
    output logic [2:0] o_phase_lo,
    output logic o_position_clk,
    output logic o_brake,
    output logic o_motor_latched,
    output logic o_irq
);
    typedef struct packed {
        logic trig_d;
        logic head_d;
        logic resel_d;
        logic [15:0] pwm_cnt;
        logic pwm_cut;
        logic [31:0] flt_cnt;
        logic latched;
        logic [2:0] hi;
        logic [2:0] lo;
        logic pos_clk;
        logic brake;
        logic heater;
        logic [ST_W-1:0] stat;
        logic [ST_W-1:0] mask;
        logic run;
        logic [15:0] duty;
        logic [31:0] rdata;
        logic irq;
    } tpms_state_t;

    tpms_state_t st_ff;
    tpms_state_t nxt_st;

    if (MIN_PRI_CYCLES < PW_VLP_CYC || MIN_PRI_CYCLES > 65535) begin : g_chk_pri
        $error("MIN_PRI_CYCLES out of range");
    end
    if (PWM_CYCLES < 2 || PWM_CYCLES > 65535) begin : g_chk_pwm
        $error("PWM_CYCLES out of range");
    end
    if (FAULT_CYCLES < 2) begin : g_chk_flt
        $error("FAULT_CYCLES too small");
    end

    localparam logic [15:0] PRI_LEN = 16'(MIN_PRI_CYCLES);
    localparam logic [15:0] PWM_LAST = 16'(PWM_CYCLES - 1);
    localparam logic [31:0] FLT_LAST = 32'(FAULT_CYCLES - 1);

    logic [1:0] sel_s;
    logic trig_s;
    logic en_s;
    logic ot_s;
    logic heat_s;
    logic head_s;
    logic [2:0] hall_s;
    logic ovs_s;
    logic oc_s;
    logic resel_s;

    // Undriven enable relies on the board pull-down to read low
    tpms_sync #(.W(13)) u_sync (
        .i_mclk(i_mclk),
        .i_reset_n(i_reset_n),
        .i_async({i_coarse_width_sel_hi, i_coarse_width_sel_lo, i_fire_trigger,
                  i_tx_enable, i_over_temp, i_heater_current_ok, i_heading_sensor_n,
                  i_rotor_sensor_c, i_rotor_sensor_b, i_rotor_sensor_a,
                  i_over_speed, i_over_current, i_tx_reselect}),
        .o_sync({sel_s, trig_s, en_s, ot_s, heat_s, head_s, hall_s, ovs_s, oc_s,
                 resel_s})
    );

    logic trig_rise;
    logic abort;
    logic fire;
    logic hold_busy;
    logic [15:0] pw_len;
    logic head_fall;

    assign trig_rise = trig_s && !st_ff.trig_d;
    assign abort = !en_s || ot_s;
    assign fire = trig_rise && !abort && !hold_busy;
    assign head_fall = !head_s && st_ff.head_d;

    always_comb begin
        unique case (sel_s)
            2'b00: pw_len = 16'(PW_SP_CYC);
            2'b01: pw_len = 16'(PW_MP_CYC);
            2'b10: pw_len = 16'(PW_LP_CYC);
            2'b11: pw_len = 16'(PW_VLP_CYC);
        endcase
    end

    // Pulse is cut short at once when enable drops or heat rises
    tpms_oneshot #(.W(16), .INV(1'b0)) u_pulse (
        .i_mclk(i_mclk),
        .i_reset_n(i_reset_n),
        .i_start(fire),
        .i_abort(abort),
        .i_len(pw_len),
        .o_out(o_tx_pulse)
    );

    // Hold-off runs on regardless of enable, so a burst cannot sneak through
    tpms_oneshot #(.W(16), .INV(1'b0)) u_hold (
        .i_mclk(i_mclk),
        .i_reset_n(i_reset_n),
        .i_start(fire),
        .i_abort(1'b0),
        .i_len(PRI_LEN),
        .o_out(hold_busy)
    );

    tpms_oneshot #(.W(16), .INV(1'b1)) u_head (
        .i_mclk(i_mclk),
        .i_reset_n(i_reset_n),
        .i_start(head_fall),
        .i_abort(1'b0),
        .i_len(16'(HEAD_CYC)),
        .o_out(o_heading_pulse_n)
    );

    function automatic logic [5:0] commutate(input logic [2:0] h);
        unique case (h)
            3'b101: commutate = {3'b001, 3'b010};
            3'b001: commutate = {3'b001, 3'b100};
            3'b011: commutate = {3'b010, 3'b100};
            3'b010: commutate = {3'b010, 3'b001};
            3'b110: commutate = {3'b100, 3'b001};
            3'b100: commutate = {3'b100, 3'b010};
            default: commutate = 6'h00;
        endcase
    endfunction : commutate

    logic [5:0] comm;
    logic hall_bad;
    logic drive_on;
    logic pwm_on;
    logic fault;
    logic [ST_W-1:0] ev;
    logic [ST_W-1:0] w1c;

    assign comm = commutate(hall_s);
    assign hall_bad = (hall_s == 3'b000) || (hall_s == 3'b111);
    assign drive_on = st_ff.run && !st_ff.latched;
    assign fault = hall_bad || oc_s;

    always_comb begin
        nxt_st = st_ff;
        ev = '0;
        w1c = '0;
        nxt_st.trig_d = trig_s;
        nxt_st.head_d = head_s;
        nxt_st.resel_d = resel_s;
        nxt_st.heater = heat_s;
        nxt_st.pos_clk = ^hall_s;
        nxt_st.brake = ovs_s;

        // PWM period counter and peak current cut
        if (st_ff.pwm_cnt >= PWM_LAST) begin
            nxt_st.pwm_cnt = '0;
            nxt_st.pwm_cut = 1'b0;
        end else begin
            nxt_st.pwm_cnt = st_ff.pwm_cnt + 16'h0001;
        end
        pwm_on = (st_ff.pwm_cnt < st_ff.duty) && !st_ff.pwm_cut;
        if (oc_s && pwm_on) begin
            nxt_st.pwm_cut = 1'b1;
            ev[ST_OCUT] = 1'b1;
        end

        // Fault persistence; a gap in the fault restarts the wait
        if (fault && drive_on) begin
            if (st_ff.flt_cnt >= FLT_LAST) begin
                nxt_st.latched = 1'b1;
                ev[ST_LATCH] = 1'b1;
            end else begin
                nxt_st.flt_cnt = st_ff.flt_cnt + 32'h0000_0001;
            end
        end else begin
            nxt_st.flt_cnt = '0;
        end
        if (resel_s && !st_ff.resel_d) begin
            nxt_st.latched = 1'b0;
            nxt_st.flt_cnt = '0;
        end

        // Bridge drive; braking shorts the windings through the low side
        if (ovs_s) begin
            nxt_st.hi = 3'b000;
            nxt_st.lo = 3'b111;
        end else if (drive_on && !(oc_s && pwm_on)) begin
            nxt_st.hi = comm[5:3];
            nxt_st.lo = pwm_on ? comm[2:0] : 3'b000;
        end else begin
            nxt_st.hi = 3'b000;
            nxt_st.lo = 3'b000;
        end

        ev[ST_FIRE] = fire;
        ev[ST_DROP] = trig_rise && !fire;
        ev[ST_HEAD] = head_fall;

        // Register writes; a new event wins over its clear
        if (i_wr) begin
            unique case (i_addr)
                REG_CTRL: nxt_st.run = i_wdata[CTRL_RUN];
                REG_STAT: w1c = i_wdata[ST_W-1:0];
                REG_MASK: nxt_st.mask = i_wdata[ST_W-1:0];
                REG_DUTY: nxt_st.duty = i_wdata[15:0];
                default: ;
            endcase
        end
        nxt_st.stat = (st_ff.stat & ~w1c) | ev;
        nxt_st.irq = |(nxt_st.stat & nxt_st.mask);

        // Read data stands for one cycle only
        nxt_st.rdata = '0;
        if (i_rd) begin
            unique case (i_addr)
                REG_CTRL: nxt_st.rdata = {31'h0000_0000, st_ff.run};
                REG_STAT: nxt_st.rdata = {27'h000_0000, st_ff.stat};
                REG_MASK: nxt_st.rdata = {27'h000_0000, st_ff.mask};
                REG_STATE: nxt_st.rdata = {21'h00_0000, ovs_s, oc_s, ot_s, en_s,
                                           st_ff.heater, st_ff.latched, hall_s,
                                           sel_s};
                REG_DUTY: nxt_st.rdata = {16'h0000, st_ff.duty};
                default: nxt_st.rdata = '0;
            endcase
        end
    end

    always_ff @(posedge i_mclk) begin
        if (!i_reset_n) begin
            st_ff <= '0;
            st_ff.run <= CTRL_RUN_RST;
            st_ff.mask <= MASK_RST;
            st_ff.duty <= DUTY_RST;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign o_rdata = st_ff.rdata;
    assign o_heater_ok = st_ff.heater;
    assign o_phase_hi = st_ff.hi;
    assign o_phase_lo = st_ff.lo;
    assign o_position_clk = st_ff.pos_clk;
    assign o_brake = st_ff.brake;
    assign o_motor_latched = st_ff.latched;
    assign o_irq = st_ff.irq;

    default clocking cb @(posedge i_mclk);
    endclocking
    default disable iff (!i_reset_n);

    // Width checker: length of each pulse not cut by abort against the decoded range
    logic [15:0] chk_len;
    logic [15:0] chk_exp;
    logic chk_cut;
    always_ff @(posedge i_mclk) begin
        if (!i_reset_n) begin
            chk_len <= '0;
            chk_exp <= '0;
            chk_cut <= 1'b0;
        end else if (fire) begin
            chk_len <= '0;
            chk_exp <= pw_len;
            chk_cut <= 1'b0;
        end else begin
            if (o_tx_pulse) begin
                chk_len <= chk_len + 16'h0001;
            end
            if (abort) begin
                chk_cut <= 1'b1;
            end
        end
    end

    property p_width;
        $fell(o_tx_pulse) && !chk_cut |-> chk_len == chk_exp;
    endproperty
    a_width: assert property (p_width) else $error("pulse width wrong");

    property p_fire;
        fire |=> o_tx_pulse ##1 (o_tx_pulse || abort || $past(abort));
    endproperty
    a_fire: assert property (p_fire) else $error("trigger did not fire");

    property p_disabled;
        !en_s |=> !o_tx_pulse;
    endproperty
    a_disabled: assert property (p_disabled) else $error("pulse while disabled");

    property p_rate;
        fire |=> (!fire)[*8];
    endproperty
    a_rate: assert property (p_rate) else $error("trigger rate not capped");

    property p_hot;
        ot_s |=> !o_tx_pulse;
    endproperty
    a_hot: assert property (p_hot) else $error("pulse while over-temperature");

    property p_heater;
        heat_s ##1 heat_s |=> o_heater_ok;
    endproperty
    a_heater: assert property (p_heater) else $error("heater status wrong");

    property p_heading;
        head_fall |=> !o_heading_pulse_n [*8];
    endproperty
    a_heading: assert property (p_heading) else $error("heading pulse missing");

    property p_cut;
        oc_s && !ovs_s |=> o_phase_lo == 3'b000;
    endproperty
    a_cut: assert property (p_cut) else $error("overcurrent did not cut");

    property p_brake;
        ovs_s |=> o_brake && o_phase_hi == 3'b000 && o_phase_lo == 3'b111;
    endproperty
    a_brake: assert property (p_brake) else $error("no braking on over-speed");

    property p_latched;
        o_motor_latched && !(resel_s && !st_ff.resel_d) && !ovs_s |=> o_phase_hi == 3'b000;
    endproperty
    a_latched: assert property (p_latched) else $error("motor driven while latched");

    property p_stay;
        o_motor_latched && !(resel_s && !st_ff.resel_d) |=> o_motor_latched;
    endproperty
    a_stay: assert property (p_stay) else $error("latch cleared without reselect");

    property p_drop;
        trig_rise && !fire |=> (!$rose(o_tx_pulse))[*3];
    endproperty
    a_drop: assert property (p_drop) else $error("dropped trigger fired later");
endmodule : tpms_top

// ### verif/tb_transmit_pulse_and_motor_supervisor.sv
// Self-checking bench for the transmit pulse and motor supervisor
`timescale 1ns/1ps
module tb_transmit_pulse_and_motor_supervisor
    import tpms_pkg::*;
;
    logic i_mclk, i_reset_n, sel_lo, sel_hi, trig, tx_en, resel;
    logic i_over_temp, i_heater_current_ok, i_heading_sensor_n, i_over_speed, i_over_current;
    logic [2:0] hall;
    logic [7:0] i_addr;
    logic [31:0] i_wdata, o_rdata, d;
    logic i_wr, i_rd, o_tx_pulse, o_heater_ok, o_heading_pulse_n, o_position_clk;
    logic o_brake, o_motor_latched, o_irq, shoot, tx_on, reselect, watch, h;
    logic [2:0] o_phase_hi, o_phase_lo;
    logic [3:0] range_sel;
    int err_total = 0;
    int total_checks = 0;
    int w, n;
    int width_tab[4] = '{PW_SP_CYC, PW_MP_CYC, PW_LP_CYC, PW_VLP_CYC};
    int range_tab[4] = '{0, 5, 8, 11};
    logic [2:0] valid_hall[6] = '{3'b101, 3'b001, 3'b011, 3'b010, 3'b110, 3'b100};

    tpms_ctrl_model ctrl (.i_mclk(i_mclk), .i_range(range_sel), .i_shoot(shoot),
        .i_tx_on(tx_on), .i_reselect(reselect), .i_watch(watch),
        .i_position_clk(o_position_clk), .o_sel_lo(sel_lo), .o_sel_hi(sel_hi),
        .o_fire_trigger(trig), .o_tx_enable(tx_en), .o_tx_reselect(resel));
    tpms_top #(.MIN_PRI_CYCLES(200), .PWM_CYCLES(20), .FAULT_CYCLES(50)) uut (
        .i_mclk(i_mclk), .i_reset_n(i_reset_n), .i_coarse_width_sel_lo(sel_lo),
        .i_coarse_width_sel_hi(sel_hi), .i_fire_trigger(trig), .i_tx_enable(tx_en),
        .i_over_temp(i_over_temp), .i_heater_current_ok(i_heater_current_ok),
        .i_heading_sensor_n(i_heading_sensor_n), .i_rotor_sensor_a(hall[0]),
        .i_rotor_sensor_b(hall[1]), .i_rotor_sensor_c(hall[2]), .i_over_speed(i_over_speed),
        .i_over_current(i_over_current), .i_tx_reselect(resel), .i_addr(i_addr),
        .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
        .o_tx_pulse(o_tx_pulse), .o_heater_ok(o_heater_ok),
        .o_heading_pulse_n(o_heading_pulse_n), .o_phase_hi(o_phase_hi),
        .o_phase_lo(o_phase_lo), .o_position_clk(o_position_clk), .o_brake(o_brake),
        .o_motor_latched(o_motor_latched), .o_irq(o_irq));

    initial begin
        i_mclk = 1'b0;
        forever #4 i_mclk = ~i_mclk;
    end

    // Reference drive pattern per hall code {c,b,a}: {high side, low side}
    function automatic logic [5:0] drive(input logic [2:0] hc);
        case (hc)
            3'b101: return 6'b001_010;
            3'b001: return 6'b001_100;
            3'b011: return 6'b010_100;
            3'b010: return 6'b010_001;
            3'b110: return 6'b100_001;
            3'b100: return 6'b100_010;
            default: return 6'b000_000;
        endcase
    endfunction : drive

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            err_total++;
            $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic cyc(input int c);
        repeat (c) @(posedge i_mclk);
    endtask : cyc

    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        @(posedge i_mclk);
        {i_wr, i_addr, i_wdata} <= {1'b1, a, v};
        @(posedge i_mclk);
        i_wr <= 1'b0;
    endtask : wr

    task automatic rd(input logic [7:0] a, output logic [31:0] v);
        @(posedge i_mclk);
        {i_rd, i_addr} <= {1'b1, a};
        @(posedge i_mclk);
        i_rd <= 1'b0;
        @(negedge i_mclk);
        v = o_rdata;
    endtask : rd

    // Fire one trigger and return the pulse length in cycles, 0 if none
    task automatic fire(output int pw);
        int t;
        pw = 0;
        @(posedge i_mclk) shoot <= 1'b1;
        @(posedge i_mclk) shoot <= 1'b0;
        for (t = 0; t < 14 && o_tx_pulse !== 1'b1; t++) @(negedge i_mclk);
        while (o_tx_pulse === 1'b1 && pw < 400) begin
            pw++;
            @(negedge i_mclk);
        end
    endtask : fire

    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : tally_and_finish

    initial begin
        repeat (100000) @(posedge i_mclk);
        err_total++;
        tally_and_finish();
    end

    initial begin
        {i_reset_n, i_over_temp, i_heater_current_ok, i_over_speed, i_over_current} = 5'h00;
        {i_wr, i_rd, shoot, tx_on, reselect, watch} = 6'h00;
        i_heading_sensor_n = 1'b1;
        hall = 3'b101;
        range_sel = 4'h0;
        i_addr = 8'h00;
        i_wdata = 32'h0000_0000;
        void'($urandom(16));
        repeat (3) @(posedge i_mclk);
        i_reset_n <= 1'b1;
        @(negedge i_mclk);
        check({o_heading_pulse_n, o_tx_pulse, o_motor_latched, o_irq, o_brake}, 5'h10);
        rd(REG_DUTY, d); check(d, DUTY_RST);
        rd(REG_CTRL, d); check(d, 32'h0000_0000);
        wr(8'h20, 32'hFFFF_FFFF);
        rd(8'h20, d); check(d, 32'h0000_0000);
        rd(REG_MASK, d); check(d, MASK_RST);
        $display("test reset done");
        tx_on <= 1'b1;
        for (int c = 0; c < 4; c++) begin
            range_sel <= range_tab[c];
            cyc(230);
            fire(w); check(w, width_tab[c]);
            rd(REG_STATE, d); check(d[1:0], c);
        end
        range_sel <= 4'h0;
        cyc(230);
        fire(w); check(w, PW_SP_CYC);
        cyc(40);
        fire(w); check(w, 0);
        rd(REG_STAT, d); check(d[1], 1'b1);
        wr(REG_STAT, 32'h0000_001F);
        cyc(200);
        check(o_tx_pulse, 1'b0);
        fire(w); check(w, PW_SP_CYC);
        $display("test trigger done");
        tx_on <= 1'b0;
        cyc(230);
        fire(w); check(w, 0);
        tx_on <= 1'b1;
        cyc(12);
        check(o_tx_pulse, 1'b0);
        i_over_temp <= 1'b1;
        cyc(6);
        fire(w); check(w, 0);
        i_over_temp <= 1'b0;
        cyc(12);
        check(o_tx_pulse, 1'b0);
        $display("test inhibit done");
        repeat (4) begin
            h = 1'($urandom % 2);
            i_heater_current_ok <= h;
            cyc(5);
            @(negedge i_mclk) check(o_heater_ok, h);
        end
        i_heading_sensor_n <= 1'b0;
        cyc(3);
        i_heading_sensor_n <= 1'b1;
        for (n = 0; n < 10 && o_heading_pulse_n !== 1'b0; n++) @(negedge i_mclk);
        for (w = 0; o_heading_pulse_n === 1'b0 && w < 5000; w++) @(negedge i_mclk);
        check(w, HEAD_CYC);
        rd(REG_STAT, d); check(d[2], 1'b1);
        $display("test heater and heading done");
        wr(REG_CTRL, 32'h0000_0001);
        repeat (12) begin
            @(posedge i_mclk) hall <= valid_hall[$urandom % 6];
            cyc(5);
            @(negedge i_mclk) check({o_phase_hi, o_phase_lo}, drive(hall));
            check(o_position_clk, ^hall);
        end
        wr(REG_DUTY, 32'h0000_0005);
        cyc(30);
        n = 0;
        repeat (40) @(negedge i_mclk) n += (o_phase_lo != 3'b000);
        check(n, 10);
        wr(REG_DUTY, 32'h0000_0014);
        wr(REG_MASK, 32'h0000_0010);
        wr(REG_STAT, 32'h0000_001F);
        // Overcurrent kept well short of the fault persistence time
        @(posedge i_mclk) i_over_current <= 1'b1;
        cyc(5);
        n = 0;
        repeat (6) @(negedge i_mclk) n += (o_phase_lo != 3'b000);
        check(n < 2, 1'b1);
        i_over_current <= 1'b0;
        cyc(4);
        @(negedge i_mclk) check(o_irq, 1'b1);
        wr(REG_STAT, 32'h0000_0010);
        cyc(2);
        @(negedge i_mclk) check(o_irq, 1'b0);
        @(posedge i_mclk) i_over_speed <= 1'b1;
        cyc(5);
        @(negedge i_mclk) check({o_brake, o_phase_hi, o_phase_lo}, 7'b1_000_111);
        i_over_speed <= 1'b0;
        $display("test motor done");
        @(posedge i_mclk) hall <= 3'b000;
        cyc(40);
        hall <= 3'b101;
        cyc(4);
        hall <= 3'b000;
        cyc(40);
        @(negedge i_mclk) check(o_motor_latched, 1'b0);
        cyc(22);
        @(negedge i_mclk) check({o_motor_latched, o_phase_hi}, 4'h8);
        @(posedge i_mclk) hall <= 3'b101;
        watch <= 1'b1;
        cyc(120);
        @(negedge i_mclk) check({o_motor_latched, o_phase_hi}, 4'h8);
        fire(w); check(w, 0);
        watch <= 1'b0;
        reselect <= 1'b1;
        cyc(6);
        @(negedge i_mclk) check(o_motor_latched, 1'b0);
        check({o_phase_hi, o_phase_lo}, drive(3'b101));
        reselect <= 1'b0;
        $display("test latch done");
        tally_and_finish();
    end
endmodule : tb_transmit_pulse_and_motor_supervisor

// ### verif/tpms_ctrl_model.sv
// Controller-side model: range to select code, trigger, enable and reselect
`timescale 1ns/1ps
module tpms_ctrl_model #(
    parameter int STOP_CYC = 100
) (
    input wire logic i_mclk,
    input wire logic [3:0] i_range,
    input wire logic i_shoot,
    input wire logic i_tx_on,
    input wire logic i_reselect,
    input wire logic i_watch,
    input wire logic i_position_clk,
    output logic o_sel_lo,
    output logic o_sel_hi,
    output logic o_fire_trigger,
    output logic o_tx_enable,
    output logic o_tx_reselect
);
    int hold;
    int still;
    logic last_pos;
    logic [1:0] code;
    // Fine trim and its stored calibration stay analogue, outside this model
    initial begin
        {o_sel_lo, o_sel_hi, o_fire_trigger, o_tx_enable, o_tx_reselect} = 5'h00;
        hold = 0;
        still = 0;
        last_pos = 1'b0;
    end
    always_comb begin
        case (i_range)
            4'h0, 4'h1, 4'h2, 4'h3, 4'h4: code = 2'b00;
            4'h5, 4'h6, 4'h7: code = 2'b01;
            4'h8, 4'h9, 4'hA: code = 2'b10;
            default: code = 2'b11;
        endcase
    end
    always @(posedge i_mclk) begin
        {o_sel_hi, o_sel_lo} <= code;
        // Trigger held a few cycles so the synchroniser cannot miss it
        hold = i_shoot ? 6 : (hold > 0 ? hold - 1 : 0);
        o_fire_trigger <= (hold > 0);
        still = (last_pos != i_position_clk) ? 0 : still + 1;
        last_pos = i_position_clk;
        // Stopped rotor means no transmission
        o_tx_enable <= i_tx_on && !(i_watch && still > STOP_CYC);
        o_tx_reselect <= i_reselect;
    end
endmodule : tpms_ctrl_model
